// ---- hdl/cpurf_top.sv ----
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cpurf_top
  import cpurf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire cpurf_wr_t i_core_wr,
  input wire cpurf_alu_t i_alu,
  input wire logic i_pc_load,
  input wire logic [19:0] i_pc_value,
  input wire cpurf_sel_t i_rd_sel,
  output logic [31:0] o_rd_data,
  output logic [19:0] o_pc,
  output logic [19:0] o_vtab,
  output logic [15:0] o_sp,
  output logic [10:0] o_flags
);

  logic [15:0] data_ff [2][4];
  logic [15:0] addr_ff [2][2];
  logic [15:0] frame_ff [2];
  logic [15:0] sbase_ff;
  logic [19:0] vtab_ff;
  logic [19:0] pc_ff;
  logic [15:0] usp_ff;
  logic [15:0] isp_ff;
  logic [10:0] flags_ff;
  logic bank;

  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  cpurf_rd_state_t rd_state_ff;

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] byte_write(input logic [15:0] old, input logic [31:0] nw,
                                             input cpurf_wmode_t mode);
    logic [15:0] r;
    r = nw[15:0];
    if (mode == CPURF_W_LOB) begin
      r = {old[15:8], nw[7:0]};
    end else if (mode == CPURF_W_HIB) begin
      r = {nw[7:0], old[7:0]};
    end
    return r;
  endfunction

  assign bank = flags_ff[FLG_B];

  // Bus write side: address and data taken in either order.
  wire bus_wr = aw_held_ff && w_held_ff && !o_bvalid;
  logic [31:0] bus_old;
  logic [31:0] bus_new;
  logic bus_hit;

  function automatic logic addr_known(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_APAIR);
  endfunction

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFF_DATA0: r = {16'h0000, data_ff[bank][0]};
      OFF_DATA1: r = {16'h0000, data_ff[bank][1]};
      OFF_DATA2: r = {16'h0000, data_ff[bank][2]};
      OFF_DATA3: r = {16'h0000, data_ff[bank][3]};
      OFF_ADDR0: r = {16'h0000, addr_ff[bank][0]};
      OFF_ADDR1: r = {16'h0000, addr_ff[bank][1]};
      OFF_FRAME: r = {16'h0000, frame_ff[bank]};
      OFF_VTAB: r = {12'h000, vtab_ff};
      OFF_PC: r = {12'h000, pc_ff};
      OFF_USP: r = {16'h0000, usp_ff};
      OFF_ISP: r = {16'h0000, isp_ff};
      OFF_SBASE: r = {16'h0000, sbase_ff};
      OFF_FLAGS: r = {21'h000000, flags_ff};
      OFF_PAIRLO: r = {data_ff[bank][2], data_ff[bank][0]};
      OFF_PAIRHI: r = {data_ff[bank][3], data_ff[bank][1]};
      OFF_APAIR: r = {addr_ff[bank][1], addr_ff[bank][0]};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // A process rather than a net, so the byte merge also follows register and bank changes, not only the address.
  always_comb begin
    bus_old = read_reg(awaddr_ff);
    bus_new = merge32(bus_old, wdata_ff, wstrb_ff);
    bus_hit = addr_known(awaddr_ff);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= i_awaddr;
    end else if (bus_wr) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= i_wdata;
      wstrb_ff <= i_wstrb;
    end else if (bus_wr) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_held_ff && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_held_ff && !(i_wvalid && o_wready) && !o_bvalid;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (bus_wr) begin
      o_bvalid <= 1'b1;
      o_bresp <= bus_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rd_state_ff <= CPURF_RD_IDLE;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else begin
      case (rd_state_ff)
        CPURF_RD_IDLE: begin
          o_arready <= 1'b1;
          if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= read_reg(i_araddr);
            o_rresp <= addr_known(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            rd_state_ff <= CPURF_RD_RESP;
          end
        end
        CPURF_RD_RESP: begin
          if (i_rready) begin
            o_rvalid <= 1'b0;
            rd_state_ff <= CPURF_RD_IDLE;
          end
        end
        default: rd_state_ff <= CPURF_RD_IDLE;
      endcase
    end
  end

  // Banked data and address registers. The core port wins over the bus when both hit one register in a cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) begin
          data_ff[b][i] <= RST_W16;
        end
        addr_ff[b][0] <= RST_W16;
        addr_ff[b][1] <= RST_W16;
        frame_ff[b] <= RST_W16;
      end
    end else begin
      if (bus_wr && bus_hit) begin
        case (awaddr_ff)
          OFF_DATA0: data_ff[bank][0] <= bus_new[15:0];
          OFF_DATA1: data_ff[bank][1] <= bus_new[15:0];
          OFF_DATA2: data_ff[bank][2] <= bus_new[15:0];
          OFF_DATA3: data_ff[bank][3] <= bus_new[15:0];
          OFF_ADDR0: addr_ff[bank][0] <= bus_new[15:0];
          OFF_ADDR1: addr_ff[bank][1] <= bus_new[15:0];
          OFF_FRAME: frame_ff[bank] <= bus_new[15:0];
          OFF_PAIRLO: begin
            data_ff[bank][0] <= bus_new[15:0];
            data_ff[bank][2] <= bus_new[31:16];
          end
          OFF_PAIRHI: begin
            data_ff[bank][1] <= bus_new[15:0];
            data_ff[bank][3] <= bus_new[31:16];
          end
          OFF_APAIR: begin
            addr_ff[bank][0] <= bus_new[15:0];
            addr_ff[bank][1] <= bus_new[31:16];
          end
          default: begin
          end
        endcase
      end
      if (i_core_wr.en) begin
        case (i_core_wr.sel)
          CPURF_SEL_D0, CPURF_SEL_D1: begin
            data_ff[bank][i_core_wr.sel[0]] <=
              byte_write(data_ff[bank][i_core_wr.sel[0]], i_core_wr.data, i_core_wr.mode);
            if (i_core_wr.mode == CPURF_W_PAIR) begin
              data_ff[bank][{1'b1, i_core_wr.sel[0]}] <= i_core_wr.data[31:16];
            end
          end
          CPURF_SEL_D2: data_ff[bank][2] <= i_core_wr.data[15:0];
          CPURF_SEL_D3: data_ff[bank][3] <= i_core_wr.data[15:0];
          CPURF_SEL_A0: begin
            addr_ff[bank][0] <= i_core_wr.data[15:0];
            if (i_core_wr.mode == CPURF_W_PAIR) begin
              addr_ff[bank][1] <= i_core_wr.data[31:16];
            end
          end
          CPURF_SEL_A1: addr_ff[bank][1] <= i_core_wr.data[15:0];
          CPURF_SEL_FB: frame_ff[bank] <= i_core_wr.data[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Unbanked pointers and bases.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sbase_ff <= RST_W16;
      vtab_ff <= RST_W20;
      usp_ff <= RST_W16;
      isp_ff <= RST_W16;
    end else begin
      if (bus_wr && bus_hit) begin
        case (awaddr_ff)
          OFF_SBASE: sbase_ff <= bus_new[15:0];
          OFF_VTAB: vtab_ff <= bus_new[19:0];
          OFF_USP: usp_ff <= bus_new[15:0];
          OFF_ISP: isp_ff <= bus_new[15:0];
          default: begin
          end
        endcase
      end
      if (i_core_wr.en) begin
        case (i_core_wr.sel)
          CPURF_SEL_SB: sbase_ff <= i_core_wr.data[15:0];
          CPURF_SEL_USP: usp_ff <= i_core_wr.data[15:0];
          CPURF_SEL_ISP: isp_ff <= i_core_wr.data[15:0];
          CPURF_SEL_SP: begin
            if (flags_ff[FLG_U]) begin
              usp_ff <= i_core_wr.data[15:0];
            end else begin
              isp_ff <= i_core_wr.data[15:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // The sequencer's load has priority over a bus write to the program counter.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pc_ff <= RST_W20;
    end else if (i_pc_load) begin
      pc_ff <= i_pc_value;
    end else if (bus_wr && bus_hit && awaddr_ff == OFF_PC) begin
      pc_ff <= bus_new[19:0];
    end
  end

  // ALU results override a same-cycle bus write of the flag word, so a live result is never lost.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags_ff <= RST_FLG;
    end else begin
      if (bus_wr && bus_hit && awaddr_ff == OFF_FLAGS) begin
        flags_ff <= bus_new[10:0] & FLG_WMASK;
      end
      if (i_alu.valid) begin
        if (i_alu.carry_en) begin
          flags_ff[FLG_C] <= i_alu.carry;
        end
        if (i_alu.zs_en) begin
          flags_ff[FLG_Z] <= (i_alu.result == 16'h0000);
          flags_ff[FLG_S] <= i_alu.result[15];
        end
        if (i_alu.ovf_en) begin
          flags_ff[FLG_O] <= i_alu.ovf;
        end
      end
    end
  end

  // Core-facing read port is registered, so it lags the selector by one cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h0000_0000;
      o_pc <= RST_W20;
      o_vtab <= RST_W20;
      o_sp <= RST_W16;
      o_flags <= RST_FLG;
    end else begin
      case (i_rd_sel)
        CPURF_SEL_D0: o_rd_data <= {data_ff[bank][2], data_ff[bank][0]};
        CPURF_SEL_D1: o_rd_data <= {data_ff[bank][3], data_ff[bank][1]};
        CPURF_SEL_D2: o_rd_data <= {16'h0000, data_ff[bank][2]};
        CPURF_SEL_D3: o_rd_data <= {16'h0000, data_ff[bank][3]};
        CPURF_SEL_A0: o_rd_data <= {addr_ff[bank][1], addr_ff[bank][0]};
        CPURF_SEL_A1: o_rd_data <= {16'h0000, addr_ff[bank][1]};
        CPURF_SEL_FB: o_rd_data <= {16'h0000, frame_ff[bank]};
        CPURF_SEL_SB: o_rd_data <= {16'h0000, sbase_ff};
        CPURF_SEL_SP: o_rd_data <= {16'h0000, flags_ff[FLG_U] ? usp_ff : isp_ff};
        CPURF_SEL_USP: o_rd_data <= {16'h0000, usp_ff};
        CPURF_SEL_ISP: o_rd_data <= {16'h0000, isp_ff};
        default: o_rd_data <= 32'h0000_0000;
      endcase
      o_pc <= pc_ff;
      o_vtab <= vtab_ff;
      o_sp <= flags_ff[FLG_U] ? usp_ff : isp_ff;
      o_flags <= flags_ff;
    end
  end

endmodule

// ---- hdl/cpurf_pkg.sv ----
package cpurf_pkg;
  // Word offsets of the register window, one aligned 32-bit word each.
  localparam logic [7:0] OFF_DATA0 = 8'h00;
  localparam logic [7:0] OFF_DATA1 = 8'h04;
  localparam logic [7:0] OFF_DATA2 = 8'h08;
  localparam logic [7:0] OFF_DATA3 = 8'h0C;
  localparam logic [7:0] OFF_ADDR0 = 8'h10;
  localparam logic [7:0] OFF_ADDR1 = 8'h14;
  localparam logic [7:0] OFF_FRAME = 8'h18;
  localparam logic [7:0] OFF_VTAB = 8'h1C;
  localparam logic [7:0] OFF_PC = 8'h20;
  localparam logic [7:0] OFF_USP = 8'h24;
  localparam logic [7:0] OFF_ISP = 8'h28;
  localparam logic [7:0] OFF_SBASE = 8'h2C;
  localparam logic [7:0] OFF_FLAGS = 8'h30;
  localparam logic [7:0] OFF_PAIRLO = 8'h34;
  localparam logic [7:0] OFF_PAIRHI = 8'h38;
  localparam logic [7:0] OFF_APAIR = 8'h3C;
  // Flag positions inside the 11-bit flag word.
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;
  localparam logic [10:0] FLG_WMASK = 11'h7FF;
  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [19:0] RST_W20 = 20'h00000;
  localparam logic [10:0] RST_FLG = 11'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selectors for the core port.
  typedef enum logic [3:0] {
    CPURF_SEL_D0 = 4'h0, CPURF_SEL_D1 = 4'h1, CPURF_SEL_D2 = 4'h2, CPURF_SEL_D3 = 4'h3,
    CPURF_SEL_A0 = 4'h4, CPURF_SEL_A1 = 4'h5, CPURF_SEL_FB = 4'h6, CPURF_SEL_SB = 4'h7,
    CPURF_SEL_SP = 4'h8, CPURF_SEL_USP = 4'h9, CPURF_SEL_ISP = 4'hA, CPURF_SEL_NONE = 4'hF
  } cpurf_sel_t;

  // Write width on the core port.
  typedef enum logic [1:0] {
    CPURF_W_WORD = 2'h0, CPURF_W_LOB = 2'h1, CPURF_W_HIB = 2'h2, CPURF_W_PAIR = 2'h3
  } cpurf_wmode_t;

  typedef struct packed {
    logic en;
    cpurf_sel_t sel;
    cpurf_wmode_t mode;
    logic [31:0] data;
  } cpurf_wr_t;

  typedef struct packed {
    logic valid;
    logic carry_en;
    logic carry;
    logic zs_en;
    logic [15:0] result;
    logic ovf_en;
    logic ovf;
  } cpurf_alu_t;

  typedef enum logic [1:0] {
    CPURF_RD_IDLE = 2'b00, CPURF_RD_RESP = 2'b01
  } cpurf_rd_state_t;
endpackage

// ---- tb/cpurf_assertions.sv ----
`timescale 1ns/1ps
module cpurf_checker
  import cpurf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire cpurf_alu_t i_alu,
  input wire logic i_pc_load,
  input wire logic [19:0] i_pc_value,
  input wire logic [19:0] o_pc,
  input wire logic [10:0] o_flags
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before it was taken");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped before it was taken");
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channel ready while a response is pending");
  a_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read address ready while read data is pending");
  a_bvalid_timing: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid)
    else $error("write response not two cycles after the handshake");
  a_rvalid_timing: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data not one cycle after the handshake");
  a_pc_load: assert property (i_pc_load |-> ##2 o_pc == $past(i_pc_value, 2))
    else $error("program counter did not take the loaded value");
  a_carry_flag: assert property (i_alu.valid && i_alu.carry_en |-> ##2 o_flags[FLG_C] == $past(i_alu.carry, 2))
    else $error("carry flag does not follow the ALU carry");
  a_zero_flag: assert property (i_alu.valid && i_alu.zs_en |-> ##2 o_flags[FLG_Z] == ($past(i_alu.result, 2) == 16'h0000))
    else $error("zero flag does not follow the result");
  a_sign_flag: assert property (i_alu.valid && i_alu.zs_en |-> ##2 o_flags[FLG_S] == $past(i_alu.result[15], 2))
    else $error("sign flag does not follow the result");
  a_ovf_flag: assert property (i_alu.valid && i_alu.ovf_en |-> ##2 o_flags[FLG_O] == $past(i_alu.ovf, 2))
    else $error("overflow flag does not follow the ALU");

  c_bus_error: cover property (o_bvalid && i_bready && o_bresp == RESP_SLVERR);
  c_read_done: cover property (o_rvalid && i_rready);
  c_alu_zero: cover property (i_alu.valid && i_alu.zs_en && i_alu.result == 16'h0000);
endmodule

bind cpurf_top cpurf_checker chk_u (.i_sys_clk, .i_sys_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
  .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .i_alu, .i_pc_load, .i_pc_value,
  .o_pc, .o_flags);

// ---- tb/cpurf_core_model.sv ----
`timescale 1ns/1ps
module cpurf_core_model
  import cpurf_pkg::*;
(
  input wire logic i_clk,
  input wire logic [31:0] i_rd_data,
  output cpurf_wr_t o_wr,
  output cpurf_alu_t o_alu,
  output logic o_pc_load,
  output logic [19:0] o_pc_value,
  output cpurf_sel_t o_rd_sel
);
  initial begin
    o_wr = '0;
    o_alu = '0;
    o_pc_load = 1'b0;
    o_pc_value = 20'h00000;
    o_rd_sel = CPURF_SEL_NONE;
  end

  task automatic core_write(input cpurf_sel_t s, input cpurf_wmode_t m, input logic [31:0] d);
    @(posedge i_clk);
    o_wr <= '{en: 1'b1, sel: s, mode: m, data: d};
    @(posedge i_clk);
    o_wr.en <= 1'b0;
  endtask

  // The sequencer never targets the debug flag, so it stays as software left it.
  task automatic alu_op(input logic ce, input logic c, input logic ze, input logic [15:0] r, input logic oe,
                        input logic o);
    @(posedge i_clk);
    o_alu <= {1'b1, ce, c, ze, r, oe, o};
    @(posedge i_clk);
    o_alu.valid <= 1'b0;
  endtask

  task automatic pc_jump(input logic [19:0] v);
    @(posedge i_clk);
    o_pc_load <= 1'b1;
    o_pc_value <= v;
    @(posedge i_clk);
    o_pc_load <= 1'b0;
  endtask

  task automatic core_read(input cpurf_sel_t s, output logic [31:0] d);
    @(posedge i_clk);
    o_rd_sel <= s;
    @(posedge i_clk);
    @(negedge i_clk);
    d = i_rd_data;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import cpurf_pkg::*;
;
  logic i_sys_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_pc_load;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, o_rd_data;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  logic [19:0] i_pc_value, o_pc, o_vtab;
  logic [15:0] o_sp;
  logic [10:0] o_flags;
  cpurf_wr_t i_core_wr;
  cpurf_alu_t i_alu;
  cpurf_sel_t i_rd_sel;
  int bad_count, checks_done;

  cpurf_top dut_u (.i_sys_clk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_core_wr, .i_alu, .i_pc_load, .i_pc_value, .i_rd_sel, .o_rd_data, .o_pc, .o_vtab, .o_sp, .o_flags);
  cpurf_core_model core_u (.i_clk(i_sys_clk), .i_rd_data(o_rd_data), .o_wr(i_core_wr), .o_alu(i_alu),
    .o_pc_load(i_pc_load), .o_pc_value(i_pc_value), .o_rd_sel(i_rd_sel));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) begin
        aw = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_sys_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(o_bresp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_sys_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk("rdata", e, o_rdata);
    chk("rresp", 32'(er), 32'(o_rresp));
  endtask

  // Offsets 0-7 hold 16-bit registers, the last two hold 20-bit ones.
  task automatic t_widths();
    logic [7:0] offs [10] = '{OFF_DATA0, OFF_DATA1, OFF_DATA2, OFF_DATA3, OFF_ADDR0, OFF_ADDR1, OFF_FRAME,
                              OFF_SBASE, OFF_VTAB, OFF_PC};
    logic [31:0] m;
    for (int i = 0; i < 10; i++) begin
      m = (i < 8) ? 32'h0000_FFFF : 32'h000F_FFFF;
      axi_wr(offs[i], 32'hDEAD_BE00 + i, 4'hF, RESP_OKAY);
      axi_rd(offs[i], (32'hDEAD_BE00 + i) & m, RESP_OKAY);
    end
    repeat (2) @(negedge i_sys_clk);
    chk("o_vtab", 32'h000D_BE08, 32'(o_vtab));
  endtask

  task automatic t_bytes();
    logic [31:0] v;
    core_u.core_write(CPURF_SEL_D0, CPURF_W_LOB, 32'h0000_0012);
    core_u.core_write(CPURF_SEL_D1, CPURF_W_HIB, 32'h0000_0034);
    axi_rd(OFF_DATA0, 32'h0000_BE12, RESP_OKAY);
    axi_rd(OFF_DATA1, 32'h0000_3401, RESP_OKAY);
    core_u.core_read(CPURF_SEL_D0, v);
    chk("core pair", 32'hBE02_BE12, v);
    core_u.core_write(CPURF_SEL_D1, CPURF_W_PAIR, 32'h1357_2468);
    axi_rd(OFF_DATA3, 32'h0000_1357, RESP_OKAY);
    axi_rd(OFF_PAIRHI, 32'h1357_2468, RESP_OKAY);
    core_u.core_write(CPURF_SEL_A0, CPURF_W_PAIR, 32'h9ABC_DEF0);
    axi_rd(OFF_ADDR1, 32'h0000_9ABC, RESP_OKAY);
    axi_rd(OFF_APAIR, 32'h9ABC_DEF0, RESP_OKAY);
    axi_wr(OFF_DATA2, 32'h0000_7700, 4'h2, RESP_OKAY);
    axi_rd(OFF_DATA2, 32'h0000_7702, RESP_OKAY);
  endtask

  task automatic t_bank();
    logic [31:0] v;
    axi_wr(OFF_FLAGS, 32'h0000_0010, 4'hF, RESP_OKAY);
    axi_wr(OFF_DATA0, 32'h0000_5555, 4'hF, RESP_OKAY);
    axi_wr(OFF_FRAME, 32'h0000_6666, 4'hF, RESP_OKAY);
    axi_wr(OFF_USP, 32'h0000_0AAA, 4'hF, RESP_OKAY);
    axi_wr(OFF_ISP, 32'h0000_0BBB, 4'hF, RESP_OKAY);
    axi_rd(OFF_SBASE, 32'h0000_BE07, RESP_OKAY);
    chk("o_sp isp", 32'h0000_0BBB, 32'(o_sp));
    axi_wr(OFF_FLAGS, 32'h0000_0080, 4'hF, RESP_OKAY);
    axi_rd(OFF_DATA0, 32'h0000_BE12, RESP_OKAY);
    axi_rd(OFF_FRAME, 32'h0000_BE06, RESP_OKAY);
    chk("o_sp usp", 32'h0000_0AAA, 32'(o_sp));
    axi_wr(OFF_FLAGS, 32'h0000_0010, 4'hF, RESP_OKAY);
    axi_rd(OFF_DATA0, 32'h0000_5555, RESP_OKAY);
    core_u.core_write(CPURF_SEL_SP, CPURF_W_WORD, 32'h0000_0CCC);
    axi_rd(OFF_ISP, 32'h0000_0CCC, RESP_OKAY);
    core_u.core_write(CPURF_SEL_FB, CPURF_W_WORD, 32'h0000_7777);
    core_u.core_read(CPURF_SEL_FB, v);
    chk("core frame", 32'h0000_7777, v);
    core_u.core_read(CPURF_SEL_SP, v);
    chk("core sp", 32'h0000_0CCC, v);
  endtask

  task automatic t_flags();
    axi_wr(OFF_FLAGS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_rd(OFF_FLAGS, 32'h0000_07FF, RESP_OKAY);
    axi_wr(OFF_FLAGS, 32'h0000_0000, 4'hF, RESP_OKAY);
    core_u.alu_op(1'b1, 1'b1, 1'b1, 16'h0000, 1'b1, 1'b0);
    repeat (2) @(negedge i_sys_clk);
    chk("flags zero", 32'h0000_0005, 32'(o_flags));
    core_u.alu_op(1'b1, 1'b0, 1'b1, 16'h8001, 1'b1, 1'b1);
    repeat (2) @(negedge i_sys_clk);
    chk("flags neg", 32'h0000_0028, 32'(o_flags));
    core_u.alu_op(1'b0, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0);
    repeat (2) @(negedge i_sys_clk);
    chk("flags kept", 32'h0000_0028, 32'(o_flags));
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    i_sys_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'h0;
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    axi_rd(OFF_FLAGS, 32'h0000_0000, RESP_OKAY);
    axi_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h02, 32'h0000_1234, 4'hF, RESP_SLVERR);
    t_widths();
    t_bytes();
    t_bank();
    t_flags();
    core_u.pc_jump(20'hABCDE);
    repeat (2) @(negedge i_sys_clk);
    chk("o_pc", 32'h000A_BCDE, 32'(o_pc));
    axi_rd(OFF_PC, 32'h000A_BCDE, RESP_OKAY);
    end_of_test();
  end
endmodule
